// ---- common/ebc_pkg.sv ----
package ebc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_TIMING0 = 8'h00;
  localparam logic [7:0] OFF_TIMING1 = 8'h04;
  localparam logic [7:0] OFF_ADDR    = 8'h08;
  localparam logic [7:0] OFF_WDATA   = 8'h0C;
  localparam logic [7:0] OFF_CTRL    = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_RDATA   = 8'h18;

  // chip_select_timing_config fields
  localparam int TF_SETUP     = 0;
  localparam int TF_WINEXT_LO = 1;
  localparam int TF_CMD_LO    = 3;
  localparam int TF_DSET      = 5;
  localparam int TF_ACC_LO    = 6;
  localparam int TF_HOLD_LO   = 11;
  localparam int TF_RDY_EN    = 13;
  localparam int TF_RDY_POL   = 14;
  localparam int TF_RDY_ASYNC = 15;

  // control and status bits
  localparam int CB_START = 0;
  localparam int CB_WRITE = 1;
  localparam int CB_WIN   = 2;
  localparam int SB_BUSY  = 0;
  localparam int SB_HACK  = 1;
  localparam int SB_DONE  = 2;

  // reset values
  localparam logic [15:0] TIMING_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;
  localparam logic [15:0] WDATA_RESET  = 16'h0000;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_SETUP    = 9'h002,
    ST_CMD      = 9'h004,
    ST_DSET     = 9'h008,
    ST_ACCESS   = 9'h010,
    ST_FHOLD    = 9'h020,
    ST_RELDRV   = 9'h040,
    ST_RELEASED = 9'h080,
    ST_REGAIN   = 9'h100
  } bus_state_t;

endpackage : ebc_pkg

// ---- src/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int                WIDTH       = 1,
  parameter logic [WIDTH-1:0]  RESET_VALUE = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds the second only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ---- src/external_bus_cycle_control.sv ----
// Behaviour
// R1: every external cycle runs setup, command delay, data setup, access, hold in order.
// R2: phase lengths come from the per-window timing configuration register.
// R3: address setup lasts one or two periods, plus zero to three on window change.
// R4: command 0-3, data setup 0-1, access 1-32, hold 0-3 periods.
// R5: with ready enabled the external module stretches the access phase.
// R6: ready input polarity is selectable, active high or active low.
// R7: synchronous ready gives the shortest cycle, no extra stage added.
// R8: asynchronous ready passes an extra stage and adds one waitstate minimum.
// R9: external asynchronous ready stays active one reference period plus setup.
// R10: external side may drop ready after the strobe rises.
// R11: external side deasserts ready before the next cycle's first sample point.
// R12: inactive sample adds a waitstate, active sample ends the cycle.
// R13: read data latched on the edge that raises the read strobe.
// R14: external side may release read data once the read strobe rose.
// R15: a hold request is granted only after the running cycle ends.
// R16: on release strobes are driven inactive, then floated, latch enable low.
// R17: bus regain starts only when the hold request goes inactive.
// R18: hold may end without own bus request; bus is regained normally.
// R19: on regain strobes are driven inactive before the next own cycle.
// R20: hold sampled on the reference clock; no cycle while acknowledge is active.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module external_bus_cycle_control (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [15:0]      addr_out,
  output logic [15:0]      data_out,
  output logic             data_oe,
  input  wire logic [15:0] data_in,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             addr_latch_enable,
  output logic             high_byte_enable_n,
  output logic             control_oe,
  input  wire logic        bus_ready_in,
  input  wire logic        hold_request_n,
  output logic             hold_acknowledge_out,
  output logic             own_bus_request_out,
  output logic             bus_reference_clock_out
);

  ebc_pkg::bus_state_t state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic        first_wait_reg, first_wait_next;
  logic [15:0] timing_reg [2];
  logic [15:0] cfg_cur_reg;
  logic [15:0] addr_cfg_reg, wdata_cfg_reg, bus_rdata_reg;
  logic        cmd_write_reg, cmd_win_reg, last_win_reg;
  logic        start_pending_reg, done_reg, hold_req_reg;
  logic        aw_held_reg, w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        rdy_s, rdy_async_reg, hold_n_s;
  logic [15:0] data_s;
  logic        wr_fire, win_change, rdy_active, leave, cycle_done, in_cycle;
  logic [15:0] cfg_sel;
  logic [31:0] wmerge, rd_word;
  logic        rd_ok;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  pin_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) u_rdy_sync (
    .ref_clk(ref_clk), .reset(reset), .pin_in(bus_ready_in), .sync_out(rdy_s));
  pin_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_hold_sync (
    .ref_clk(ref_clk), .reset(reset), .pin_in(hold_request_n), .sync_out(hold_n_s));
  pin_sync #(.WIDTH(16), .RESET_VALUE(16'h0000)) u_data_sync (
    .ref_clk(ref_clk), .reset(reset), .pin_in(data_in), .sync_out(data_s));

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  // next phase, skipping phases programmed to zero length
  function automatic ebc_pkg::bus_state_t advance(input ebc_pkg::bus_state_t from, input logic [15:0] cfg);
    ebc_pkg::bus_state_t n;
    n = ebc_pkg::ST_IDLE;
    if (from == ebc_pkg::ST_SETUP && cfg[ebc_pkg::TF_CMD_LO +: 2] != 2'h0) begin
      n = ebc_pkg::ST_CMD;
    end else if ((from == ebc_pkg::ST_SETUP || from == ebc_pkg::ST_CMD) && cfg[ebc_pkg::TF_DSET]) begin
      n = ebc_pkg::ST_DSET;
    end else if (from == ebc_pkg::ST_SETUP || from == ebc_pkg::ST_CMD || from == ebc_pkg::ST_DSET) begin
      n = ebc_pkg::ST_ACCESS;
    end else if (from == ebc_pkg::ST_ACCESS && cfg[ebc_pkg::TF_HOLD_LO +: 2] != 2'h0) begin
      n = ebc_pkg::ST_FHOLD;
    end
    return n;
  endfunction : advance

  // phase length minus one, in cpu_clock_period units
  function automatic logic [4:0] phase_len(input ebc_pkg::bus_state_t st, input logic [15:0] cfg,
                                           input logic chg);
    logic [4:0] l;
    l = 5'h00;
    if (st == ebc_pkg::ST_SETUP) begin
      l = {4'h0, cfg[ebc_pkg::TF_SETUP]} + (chg ? {3'h0, cfg[ebc_pkg::TF_WINEXT_LO +: 2]} : 5'h00); // R3
    end else if (st == ebc_pkg::ST_CMD) begin
      l = {3'h0, cfg[ebc_pkg::TF_CMD_LO +: 2]} - 5'h01; // R4
    end else if (st == ebc_pkg::ST_ACCESS) begin
      l = cfg[ebc_pkg::TF_ACC_LO +: 5]; // R4
    end else if (st == ebc_pkg::ST_FHOLD) begin
      l = {3'h0, cfg[ebc_pkg::TF_HOLD_LO +: 2]} - 5'h01; // R4
    end
    return l;
  endfunction : phase_len

  assign cfg_sel    = timing_reg[cmd_win_reg]; // R2
  assign win_change = cmd_win_reg != last_win_reg;
  // async adds a third stage; sync pays only the metastability pair
  assign rdy_active = (cfg_cur_reg[ebc_pkg::TF_RDY_ASYNC] ? rdy_async_reg : rdy_s)
                      == cfg_cur_reg[ebc_pkg::TF_RDY_POL]; // R6 R7 R8
  assign in_cycle   = !(state_reg inside {ebc_pkg::ST_IDLE, ebc_pkg::ST_RELDRV,
                                          ebc_pkg::ST_RELEASED, ebc_pkg::ST_REGAIN});
  assign cycle_done = in_cycle && state_next == ebc_pkg::ST_IDLE;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdy_async_reg <= 1'b0;
    end else begin
      rdy_async_reg <= rdy_s; // R8
    end
  end

  always_comb begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    first_wait_next = first_wait_reg;
    leave           = 1'b0;
    unique case (state_reg)
      ebc_pkg::ST_IDLE: begin
        if (hold_req_reg) begin
          state_next = ebc_pkg::ST_RELDRV; // R15
        end else if (start_pending_reg) begin
          state_next = ebc_pkg::ST_SETUP; // R1
          cnt_next   = phase_len(ebc_pkg::ST_SETUP, cfg_sel, win_change); // R3
        end
      end
      ebc_pkg::ST_SETUP, ebc_pkg::ST_CMD, ebc_pkg::ST_DSET: begin
        if (cnt_reg == 5'h00) begin
          state_next      = advance(state_reg, cfg_cur_reg); // R1
          cnt_next        = phase_len(state_next, cfg_cur_reg, 1'b0); // R2
          first_wait_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      ebc_pkg::ST_ACCESS: begin
        if (cnt_reg != 5'h00) begin
          cnt_next = cnt_reg - 5'h01;
        end else if (!cfg_cur_reg[ebc_pkg::TF_RDY_EN]) begin
          leave = 1'b1;
        end else if (cfg_cur_reg[ebc_pkg::TF_RDY_ASYNC] && first_wait_reg) begin
          first_wait_next = 1'b0; // R8
        end else if (rdy_active) begin
          leave = 1'b1; // R5 R12
        end
        if (leave) begin
          state_next = advance(ebc_pkg::ST_ACCESS, cfg_cur_reg); // R1
          cnt_next   = phase_len(state_next, cfg_cur_reg, 1'b0);
        end
      end
      ebc_pkg::ST_FHOLD: begin
        if (cnt_reg == 5'h00) begin
          state_next = ebc_pkg::ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      ebc_pkg::ST_RELDRV: begin
        state_next = ebc_pkg::ST_RELEASED; // R16
      end
      ebc_pkg::ST_RELEASED: begin
        if (!hold_req_reg) begin
          state_next = ebc_pkg::ST_REGAIN; // R17 R18
        end
      end
      ebc_pkg::ST_REGAIN: begin
        state_next = ebc_pkg::ST_IDLE; // R19
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg      <= ebc_pkg::ST_IDLE;
      cnt_reg        <= 5'h00;
      first_wait_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      first_wait_reg <= first_wait_next;
    end
  end

  // reference clock toggles each period; hold is taken just before its rising edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_reference_clock_out <= 1'b0;
      hold_req_reg            <= 1'b0;
    end else begin
      bus_reference_clock_out <= !bus_reference_clock_out;
      if (!bus_reference_clock_out) begin
        hold_req_reg <= !hold_n_s; // R20
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_cur_reg  <= ebc_pkg::TIMING_RESET;
      last_win_reg <= 1'b0;
    end else if (state_reg == ebc_pkg::ST_IDLE && state_next == ebc_pkg::ST_SETUP) begin
      cfg_cur_reg  <= cfg_sel; // R2
      last_win_reg <= cmd_win_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_latch_enable    <= 1'b0;
      read_strobe_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      data_oe              <= 1'b0;
      control_oe           <= 1'b1;
      high_byte_enable_n   <= 1'b1;
      hold_acknowledge_out <= 1'b0;
      own_bus_request_out  <= 1'b0;
      addr_out             <= ebc_pkg::ADDR_RESET;
      data_out             <= ebc_pkg::WDATA_RESET;
    end else begin
      addr_latch_enable    <= state_next == ebc_pkg::ST_SETUP; // R16 R19
      read_strobe_n        <= !(state_next == ebc_pkg::ST_ACCESS && !cmd_write_reg); // R20
      write_strobe_n       <= !(state_next == ebc_pkg::ST_ACCESS && cmd_write_reg); // R20
      data_oe              <= cmd_write_reg && (state_next inside {ebc_pkg::ST_DSET, ebc_pkg::ST_ACCESS,
                                                                   ebc_pkg::ST_FHOLD});
      control_oe           <= state_next != ebc_pkg::ST_RELEASED; // R16 R19
      high_byte_enable_n   <= state_next inside {ebc_pkg::ST_IDLE, ebc_pkg::ST_RELDRV,
                                                 ebc_pkg::ST_RELEASED, ebc_pkg::ST_REGAIN};
      hold_acknowledge_out <= state_next == ebc_pkg::ST_RELEASED; // R15 R20
      own_bus_request_out  <= state_next == ebc_pkg::ST_RELEASED && start_pending_reg;
      if (state_reg == ebc_pkg::ST_IDLE && state_next == ebc_pkg::ST_SETUP) begin
        addr_out <= addr_cfg_reg;
        data_out <= wdata_cfg_reg;
      end
    end
  end

  // read data taken on the same edge that raises the read strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_rdata_reg <= 16'h0000;
    end else if (state_reg == ebc_pkg::ST_ACCESS && state_next != ebc_pkg::ST_ACCESS && !cmd_write_reg) begin
      bus_rdata_reg <= data_s; // R13
    end
  end

  // axi4-lite write path: address and data taken in either order
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ebc_pkg::RESP_OKAY;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg inside {ebc_pkg::OFF_TIMING0, ebc_pkg::OFF_TIMING1, ebc_pkg::OFF_ADDR,
                         ebc_pkg::OFF_WDATA, ebc_pkg::OFF_CTRL}) ? ebc_pkg::RESP_OKAY : ebc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wmerge = 32'h0000_0000;
    unique case (awaddr_reg)
      ebc_pkg::OFF_TIMING0: wmerge = apply_strb({16'h0000, timing_reg[0]}, wdata_reg, wstrb_reg);
      ebc_pkg::OFF_TIMING1: wmerge = apply_strb({16'h0000, timing_reg[1]}, wdata_reg, wstrb_reg);
      ebc_pkg::OFF_ADDR:    wmerge = apply_strb({16'h0000, addr_cfg_reg}, wdata_reg, wstrb_reg);
      ebc_pkg::OFF_WDATA:   wmerge = apply_strb({16'h0000, wdata_cfg_reg}, wdata_reg, wstrb_reg);
      default:              wmerge = apply_strb(32'h0000_0000, wdata_reg, wstrb_reg);
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timing_reg[0] <= ebc_pkg::TIMING_RESET;
      timing_reg[1] <= ebc_pkg::TIMING_RESET;
      addr_cfg_reg  <= ebc_pkg::ADDR_RESET;
      wdata_cfg_reg <= ebc_pkg::WDATA_RESET;
    end else if (wr_fire) begin
      if (awaddr_reg == ebc_pkg::OFF_TIMING0) timing_reg[0] <= wmerge[15:0];
      if (awaddr_reg == ebc_pkg::OFF_TIMING1) timing_reg[1] <= wmerge[15:0];
      if (awaddr_reg == ebc_pkg::OFF_ADDR) addr_cfg_reg <= wmerge[15:0];
      if (awaddr_reg == ebc_pkg::OFF_WDATA) wdata_cfg_reg <= wmerge[15:0];
    end
  end

  // a start while one is pending is ignored; done set beats its clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      start_pending_reg <= 1'b0;
      cmd_write_reg     <= 1'b0;
      cmd_win_reg       <= 1'b0;
      done_reg          <= 1'b0;
    end else begin
      if (wr_fire && awaddr_reg == ebc_pkg::OFF_CTRL && !start_pending_reg && !in_cycle) begin
        cmd_write_reg     <= wmerge[ebc_pkg::CB_WRITE];
        cmd_win_reg       <= wmerge[ebc_pkg::CB_WIN];
        start_pending_reg <= wmerge[ebc_pkg::CB_START];
      end else if (state_reg == ebc_pkg::ST_IDLE && state_next == ebc_pkg::ST_SETUP) begin
        start_pending_reg <= 1'b0;
      end
      if (cycle_done) begin
        done_reg <= 1'b1;
      end else if (wr_fire && awaddr_reg == ebc_pkg::OFF_CTRL && wmerge[ebc_pkg::CB_START]) begin
        done_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      ebc_pkg::OFF_TIMING0: rd_word = {16'h0000, timing_reg[0]};
      ebc_pkg::OFF_TIMING1: rd_word = {16'h0000, timing_reg[1]};
      ebc_pkg::OFF_ADDR:    rd_word = {16'h0000, addr_cfg_reg};
      ebc_pkg::OFF_WDATA:   rd_word = {16'h0000, wdata_cfg_reg};
      ebc_pkg::OFF_CTRL:    rd_word = {29'h0000_0000, cmd_win_reg, cmd_write_reg, start_pending_reg};
      ebc_pkg::OFF_STATUS:  rd_word = {29'h0000_0000, done_reg, hold_acknowledge_out,
                                       start_pending_reg | in_cycle};
      ebc_pkg::OFF_RDATA:   rd_word = {16'h0000, bus_rdata_reg};
      default:              rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ebc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? ebc_pkg::RESP_OKAY : ebc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  a_access_entry: assert property ( // R1
    state_reg == ebc_pkg::ST_ACCESS && $past(state_reg) != ebc_pkg::ST_ACCESS
    |-> $past(state_reg) inside {ebc_pkg::ST_SETUP, ebc_pkg::ST_CMD, ebc_pkg::ST_DSET})
    else $error("access phase entered out of order");

  a_setup_short: assert property ( // R3
    state_reg == ebc_pkg::ST_IDLE && state_next == ebc_pkg::ST_SETUP && !cfg_sel[ebc_pkg::TF_SETUP] && !win_change
    |=> addr_latch_enable ##1 !addr_latch_enable)
    else $error("one period address setup wrong");

  a_access_min: assert property ( // R4
    $fell(read_strobe_n) && cfg_cur_reg[ebc_pkg::TF_ACC_LO +: 5] == 5'h00 && !cfg_cur_reg[ebc_pkg::TF_RDY_EN]
    |=> $rose(read_strobe_n))
    else $error("single period access wrong");

  a_ready_stall: assert property ( // R12
    state_reg == ebc_pkg::ST_ACCESS && cnt_reg == 5'h00 && cfg_cur_reg[ebc_pkg::TF_RDY_EN]
    && !cfg_cur_reg[ebc_pkg::TF_RDY_ASYNC] && !rdy_active |=> state_reg == ebc_pkg::ST_ACCESS)
    else $error("inactive ready did not add waitstate");

  a_ready_end: assert property ( // R5
    state_reg == ebc_pkg::ST_ACCESS && cnt_reg == 5'h00 && cfg_cur_reg[ebc_pkg::TF_RDY_EN]
    && !cfg_cur_reg[ebc_pkg::TF_RDY_ASYNC] && rdy_active |=> state_reg != ebc_pkg::ST_ACCESS)
    else $error("active ready did not end access");

  a_async_wait: assert property ( // R8
    state_reg == ebc_pkg::ST_ACCESS && cnt_reg == 5'h00 && first_wait_reg
    && cfg_cur_reg[ebc_pkg::TF_RDY_EN] && cfg_cur_reg[ebc_pkg::TF_RDY_ASYNC]
    |=> state_reg == ebc_pkg::ST_ACCESS)
    else $error("async ready missed mandatory waitstate");

  a_rdata_edge: assert property ( // R13
    $rose(read_strobe_n) |-> bus_rdata_reg == $past(data_s))
    else $error("read data not taken at strobe rise");

  a_grant_after: assert property ( // R15
    $rose(hold_acknowledge_out) |-> $past(state_reg) == ebc_pkg::ST_RELDRV
    && $past(read_strobe_n) && $past(write_strobe_n) && $past(control_oe))
    else $error("bus granted without inactive drive");

  a_release_float: assert property ( // R16
    hold_acknowledge_out |-> !control_oe && !addr_latch_enable)
    else $error("released bus still driven");

  a_regain_hold: assert property ( // R17
    hold_acknowledge_out && hold_req_reg |=> hold_acknowledge_out)
    else $error("bus regained while hold active");

  a_regain_drive: assert property ( // R19
    $fell(hold_acknowledge_out) |-> control_oe && read_strobe_n && write_strobe_n && !addr_latch_enable
    ##1 state_reg == ebc_pkg::ST_IDLE)
    else $error("regain did not drive strobes inactive");

  a_no_cycle_held: assert property ( // R20
    hold_acknowledge_out |-> read_strobe_n && write_strobe_n && high_byte_enable_n)
    else $error("cycle driven while acknowledged");

endmodule : external_bus_cycle_control
`default_nettype wire

// ---- dv/ext_memory_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ext_memory_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] addr_out,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        high_byte_enable_n,
  input  wire logic        ready_pol,
  input  wire logic [3:0]  ready_delay,
  output logic [15:0]      data_in,
  output logic             bus_ready_in
);
  logic [3:0] cnt;
  logic       on;
  assign on = !read_strobe_n || !write_strobe_n;
  initial begin
    cnt = 4'h0;
    data_in = 16'h0000;
    bus_ready_in = 1'b0;
  end
  always @(posedge ref_clk) begin
    cnt <= on ? cnt + 4'h1 : 4'h0;
    // held until the strobe rises, so gone before the next cycle
    bus_ready_in <= (on && cnt >= ready_delay) ? ready_pol : !ready_pol;
    // released data toggles, never keeps the last value
    data_in <= (!high_byte_enable_n && write_strobe_n) ? ~addr_out : {data_in[14:0], !data_in[15]};
  end
endmodule : ext_memory_model
`default_nettype wire

// ---- dv/external_bus_cycle_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t got %h", $time, a); end end
module external_bus_cycle_control_test;
  logic        ref_clk = 0, reset = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, hold_n = 1, pol = 1, clr = 0;
  logic [7:0]  aw = 0, ar = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0]  dly = 0;
  logic [15:0] din, addr;
  logic [1:0]  br, rr;
  logic        awr, wr, bv, arr, rv, rdn, wrn, ale, hbe, coe, hack, rdy, doe, obr, rclk, rc0;
  logic [15:0] dout;
  int          miscompares = 0, n_tests = 0, k, na, ns, nsy, nd, nh;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    na <= clr ? 0 : na + ale;
    ns <= clr ? 0 : ns + !rdn + !wrn;
    nd <= clr ? 0 : nd + doe;
    nh <= clr ? 0 : nh + !hbe;
  end
  external_bus_cycle_control uut (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .addr_out(addr), .data_out(dout), .data_oe(doe), .data_in(din), .read_strobe_n(rdn), .write_strobe_n(wrn),
    .addr_latch_enable(ale), .high_byte_enable_n(hbe), .control_oe(coe), .bus_ready_in(rdy),
    .hold_request_n(hold_n), .hold_acknowledge_out(hack), .own_bus_request_out(obr),
    .bus_reference_clock_out(rclk));
  ext_memory_model mem (.ref_clk(ref_clk), .addr_out(addr), .read_strobe_n(rdn), .write_strobe_n(wrn),
    .high_byte_enable_n(hbe), .ready_pol(pol), .ready_delay(dly), .data_in(din), .bus_ready_in(rdy));
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // every open-ended wait goes through here, so none can hang
  task automatic step;
    @(posedge ref_clk);
    k++;
    if (k > 400) begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  endtask : step
  task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bit ta, tw;
    ta = 0;
    tw = 0;
    k = 0;
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!(ta && tw)) begin
      step();
      if (awr) begin ta = 1; awv <= 0; end
      if (wr) begin tw = 1; wv <= 0; end
    end
    do step(); while (!bv);
    bry <= 0;
    `CHK(br, e)
    step();
  endtask : wr32
  task automatic rd32(input logic [7:0] a);
    k = 0;
    ar <= a;
    arv <= 1;
    rry <= 1;
    do step(); while (!arr);
    arv <= 0;
    do step(); while (!rv);
    rry <= 0;
    `CHK(rr, ebc_pkg::RESP_OKAY)
    step();
  endtask : rd32
  task automatic run(input logic [31:0] c);
    clr <= 1;
    step();
    clr <= 0;
    wr32(ebc_pkg::OFF_CTRL, c, ebc_pkg::RESP_OKAY);
    while (ns == 0 || !hbe) step();
  endtask : run
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    rc0 = rclk;
    step();
    `CHK(rclk, !rc0)
    rd32(ebc_pkg::OFF_TIMING0);
    `CHK(rd[15:0], ebc_pkg::TIMING_RESET)
    wr32(8'h40, 32'h0, ebc_pkg::RESP_SLVERR);
    wr32(ebc_pkg::OFF_STATUS, 0, ebc_pkg::RESP_SLVERR);
    wr32(ebc_pkg::OFF_TIMING0, 32'h00C1, ebc_pkg::RESP_OKAY);
    wr32(ebc_pkg::OFF_ADDR, 32'h1234, ebc_pkg::RESP_OKAY);
    run(1);
    `CHK(na, 2)
    `CHK(ns, 4)
    rd32(ebc_pkg::OFF_RDATA);
    `CHK(rd[15:0], 16'hEDCB)
    // window change stretches setup once only
    wr32(ebc_pkg::OFF_TIMING1, 32'h0004, ebc_pkg::RESP_OKAY);
    run(5);
    `CHK(na, 3)
    run(5);
    `CHK(na, 1)
    `CHK(ns, 1)
    dly <= 4'h6;
    wr32(ebc_pkg::OFF_TIMING0, 32'h6000, ebc_pkg::RESP_OKAY);
    run(1);
    `CHK(ns > 6, 1'b1)
    nsy = ns;
    pol <= 1'b0;
    wr32(ebc_pkg::OFF_TIMING0, 32'hA000, ebc_pkg::RESP_OKAY);
    run(1);
    `CHK(ns > nsy, 1'b1)
    // write with command, data setup, access and hold programmed non-zero
    wr32(ebc_pkg::OFF_WDATA, 32'h5AA5, ebc_pkg::RESP_OKAY);
    wr32(ebc_pkg::OFF_TIMING0, 32'h1870, ebc_pkg::RESP_OKAY);
    run(32'h3);
    `CHK(ns, 2)
    `CHK(nd, 6)
    `CHK(nh, 9)
    `CHK(dout, 16'h5AA5)
    // hold arrives inside a 32-period access
    wr32(ebc_pkg::OFF_TIMING0, 32'h07C0, ebc_pkg::RESP_OKAY);
    clr <= 1;
    wr32(ebc_pkg::OFF_CTRL, 1, ebc_pkg::RESP_OKAY);
    clr <= 0;
    hold_n <= 1'b0;
    while (!hack) step();
    `CHK(ns, 32)
    `CHK({coe, ale}, 2'b00)
    wr32(ebc_pkg::OFF_CTRL, 1, ebc_pkg::RESP_OKAY);
    repeat (10) step();
    `CHK(ns, 32)
    `CHK(obr, 1'b1)
    hold_n <= 1'b1;
    while (hack) step();
    `CHK({coe, rdn, wrn}, 3'b111)
    while (ns == 32 || !hbe) step();
    `CHK(ns, 64)
    // hold with no own request pending, then plain regain
    hold_n <= 1'b0;
    while (!hack) step();
    `CHK(obr, 1'b0)
    hold_n <= 1'b1;
    while (hack) step();
    `CHK({coe, hbe}, 2'b11)
    stop_test();
  end
endmodule : external_bus_cycle_control_test
`default_nettype wire
